// >>> common/utx_pkg.sv
// Constants for the serial transmit FIFO and transfer request block.
// Assumes a single core clock domain and the plain register port.
package utx_pkg;
  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ENHANCED_FEATURE_OFF = 8'h08;
  localparam logic [7:0] LINE_CONTROL_OFF = 8'h0c;
  localparam logic [7:0] MODEM_CONTROL_OFF = 8'h10;
  localparam logic [7:0] TRIGGER_LEVEL_OFF = 8'h1c;
  localparam logic [7:0] SUPPLEMENTARY_OFF = 8'h40;
  localparam logic [7:0] MODE_DEF_3_OFF = 8'h80;
  localparam logic [7:0] TX_DMA_THRESH_OFF = 8'h84;
  localparam logic [7:0] TX_DATA_OFF = 8'h00;
  localparam logic [7:0] FIFO_STATUS_OFF = 8'h88;
  // ---------------------------------------------------------------
  // Field positions and key values
  // ---------------------------------------------------------------
  localparam logic [7:0] PORTAL_UNLOCK_VAL = 8'hbf;
  localparam logic [7:0] PORTAL_FIFO_VAL = 8'h00;
  localparam int ENHANCED_EN_BIT = 4;
  localparam int TRIG_ACCESS_BIT = 6;
  localparam int FINE_GRAN_BIT = 6;
  localparam int DMA_THRESH_EN_BIT = 2;
  localparam int FIFO_CTRL_TRIG_LO = 4;
  // ---------------------------------------------------------------
  // Sizes and reset values
  // ---------------------------------------------------------------
  localparam int FIFO_DEPTH = 64;
  localparam int FIFO_WIDTH = 8;
  localparam int CNT_W = 7;
  localparam int STAGE_DEPTH = 16;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [5:0] DEFAULT_THRESH = 6'h00;
endpackage : utx_pkg

// >>> design/utx_tx_dma_request.sv
// Serial transmit FIFO, its configuration portal and transfer request.
// Assumes register port and transmit drain in the core clock domain.
`timescale 1ns/1ns

// -----------------------------------------------------------------
// Small parameterised staging FIFO
// -----------------------------------------------------------------
module utx_stage_fifo
  import utx_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : utx_stage_fifo

// -----------------------------------------------------------------
// Top level
// -----------------------------------------------------------------
module utx_tx_dma_request
  import utx_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Transmitter drain side
  input wire logic tx_take,
  output logic tx_avail,
  output logic [7:0] tx_byte,
  // Toward the DMA controller
  output logic serial_tx_transfer_request
);
  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  logic [7:0] line_control_portal_reg;
  logic [7:0] enhanced_feature_reg;
  logic [7:0] modem_control_reg;
  logic [7:0] trigger_level_reg;
  logic [7:0] supplementary_control_reg;
  logic [7:0] mode_definition_3_reg;
  logic [7:0] tx_dma_threshold_reg;
  logic [7:0] fifo_control_reg;
  logic [7:0] reg_rdata_reg;
  logic enhanced_function_enable;
  logic tx_trigger_fine_granularity;
  logic feature_open;
  logic trigger_open;
  logic wr_hit_portal;
  logic wr_shared;

  assign enhanced_function_enable = enhanced_feature_reg[ENHANCED_EN_BIT];
  assign tx_trigger_fine_granularity = supplementary_control_reg[FINE_GRAN_BIT];
  assign feature_open = (line_control_portal_reg == PORTAL_UNLOCK_VAL);
  // Trigger level is open only with enhanced enable and modem control bit 6 set
  assign trigger_open = enhanced_function_enable && modem_control_reg[TRIG_ACCESS_BIT];
  assign wr_hit_portal = reg_wr && (reg_addr == LINE_CONTROL_OFF);
  assign wr_shared = reg_wr && (reg_addr == ENHANCED_FEATURE_OFF);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      line_control_portal_reg <= REG_RESET;
    end else if (wr_hit_portal) begin
      line_control_portal_reg <= reg_wdata;
    end
  end

  // Offset 08h is the feature register while unlocked, FIFO control while the portal holds 00h
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      enhanced_feature_reg <= REG_RESET;
      fifo_control_reg <= REG_RESET;
    end else if (wr_shared) begin
      if (feature_open) begin
        enhanced_feature_reg <= reg_wdata;
      end else if (line_control_portal_reg == PORTAL_FIFO_VAL) begin
        fifo_control_reg <= reg_wdata;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      modem_control_reg <= REG_RESET;
    end else if (reg_wr && reg_addr == MODEM_CONTROL_OFF && enhanced_function_enable) begin
      modem_control_reg <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      trigger_level_reg <= REG_RESET;
    end else if (reg_wr && reg_addr == TRIGGER_LEVEL_OFF && trigger_open) begin
      trigger_level_reg <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      supplementary_control_reg <= REG_RESET;
      mode_definition_3_reg <= REG_RESET;
      tx_dma_threshold_reg <= REG_RESET;
    end else if (reg_wr) begin
      if (reg_addr == SUPPLEMENTARY_OFF) begin
        supplementary_control_reg <= reg_wdata;
      end
      if (reg_addr == MODE_DEF_3_OFF) begin
        mode_definition_3_reg <= reg_wdata;
      end
      if (reg_addr == TX_DMA_THRESH_OFF) begin
        tx_dma_threshold_reg <= {2'b00, reg_wdata[5:0]};
      end
    end
  end

  // ---------------------------------------------------------------
  // Data path: staging FIFO then 64-entry transmit FIFO
  // ---------------------------------------------------------------
  logic stage_valid;
  logic stage_ready;
  logic [7:0] stage_data;
  logic stage_in_ready;
  logic [7:0] txf_mem_reg [FIFO_DEPTH];
  logic [5:0] txf_wr_reg;
  logic [5:0] txf_rd_reg;
  logic [CNT_W-1:0] txf_count_reg;
  logic txf_full;
  logic txf_push;
  logic txf_pop;

  // Writes while staging is full are dropped; software paces by requests
  utx_stage_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(STAGE_DEPTH)
  ) u_stage (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .in_valid(reg_wr && reg_addr == TX_DATA_OFF),
    .in_ready(stage_in_ready),
    .in_data(reg_wdata),
    .out_valid(stage_valid),
    .out_ready(stage_ready),
    .out_data(stage_data)
  );

  assign txf_full = (txf_count_reg == CNT_W'(FIFO_DEPTH));
  assign stage_ready = !txf_full;
  assign txf_push = stage_valid && stage_ready;
  assign txf_pop = tx_take && (txf_count_reg != '0);
  assign tx_avail = (txf_count_reg != '0);
  assign tx_byte = txf_mem_reg[txf_rd_reg];

  always_ff @(posedge core_clk) begin
    if (txf_push) begin
      txf_mem_reg[txf_wr_reg] <= stage_data;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      txf_wr_reg <= '0;
      txf_rd_reg <= '0;
      txf_count_reg <= '0;
    end else begin
      if (txf_push) begin
        txf_wr_reg <= txf_wr_reg + 1'b1;
      end
      if (txf_pop) begin
        txf_rd_reg <= txf_rd_reg + 1'b1;
      end
      txf_count_reg <= txf_count_reg + CNT_W'(txf_push) - CNT_W'(txf_pop);
    end
  end

  // ---------------------------------------------------------------
  // Full flag crossing and request generation
  // ---------------------------------------------------------------
  logic full_meta_reg;
  logic full_sync_reg;
  logic [CNT_W-1:0] trig_level;
  logic [CNT_W-1:0] space;
  logic req_cond;
  logic req_cond_reg;
  logic serial_tx_transfer_request_reg;

  // Full treated as foreign to this domain; costs two cycles of lag
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      full_meta_reg <= 1'b0;
      full_sync_reg <= 1'b0;
    end else begin
      full_meta_reg <= txf_full;
      full_sync_reg <= full_meta_reg;
    end
  end

  // Fine mode: {trigger 3:0, FIFO control 5:4}; coarse: control 5:4 times 8
  always_comb begin
    if (tx_trigger_fine_granularity) begin
      trigger_level_computed: begin
        trig_level = {1'b0, trigger_level_reg[3:0], fifo_control_reg[FIFO_CTRL_TRIG_LO+:2]};
      end
    end else begin
      trig_level = {fifo_control_reg[FIFO_CTRL_TRIG_LO+:2], 5'b00000} >> 2;
    end
  end

  assign space = CNT_W'(FIFO_DEPTH) - txf_count_reg;

  // Threshold mode: request while fill at or below threshold
  always_comb begin
    if (full_sync_reg) begin
      req_cond = 1'b0;
    end else if (mode_definition_3_reg[DMA_THRESH_EN_BIT]) begin
      req_cond = (txf_count_reg <= {1'b0, tx_dma_threshold_reg[5:0]});
    end else begin
      req_cond = (space >= trig_level) && (trig_level != '0);
    end
  end

  // One pulse per rising change of the condition; software sizing
  // keeps full from toggling it
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      req_cond_reg <= 1'b0;
      serial_tx_transfer_request_reg <= 1'b0;
    end else begin
      req_cond_reg <= req_cond;
      serial_tx_transfer_request_reg <= req_cond && !req_cond_reg;
    end
  end

  assign serial_tx_transfer_request = serial_tx_transfer_request_reg;

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_reg <= REG_RESET;
    end else if (reg_rd) begin
      case (reg_addr)
        ENHANCED_FEATURE_OFF: reg_rdata_reg <= feature_open ? enhanced_feature_reg : fifo_control_reg;
        LINE_CONTROL_OFF: reg_rdata_reg <= line_control_portal_reg;
        MODEM_CONTROL_OFF: reg_rdata_reg <= modem_control_reg;
        TRIGGER_LEVEL_OFF: reg_rdata_reg <= trigger_open ? trigger_level_reg : REG_RESET;
        SUPPLEMENTARY_OFF: reg_rdata_reg <= supplementary_control_reg;
        MODE_DEF_3_OFF: reg_rdata_reg <= mode_definition_3_reg;
        TX_DMA_THRESH_OFF: reg_rdata_reg <= tx_dma_threshold_reg;
        FIFO_STATUS_OFF: reg_rdata_reg <= {stage_in_ready, txf_count_reg};
        default: reg_rdata_reg <= REG_RESET;
      endcase
    end else begin
      reg_rdata_reg <= REG_RESET;
    end
  end

  assign reg_rdata = reg_rdata_reg;
endmodule : utx_tx_dma_request

// >>> sim/utx_dma_ctrl_model.sv
// Stand-in for the interconnect DMA controller.
// Assumes the block's clock and reset; only counts request pulses.
`timescale 1ns/1ns
module utx_dma_ctrl_model
  import utx_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Request from the block
  input wire logic serial_tx_transfer_request,
  // Observation
  output int req_count
);
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      req_count <= 0;
    end else if (serial_tx_transfer_request) begin
      req_count <= req_count + 1;
    end
  end
endmodule : utx_dma_ctrl_model

// >>> sim/utx_tx_dma_request_checker.sv
// Port checker for the transmit FIFO and transfer request block.
// Assumes one clock domain; bound to the top module below.
`timescale 1ns/1ns
module utx_tx_dma_request_checker
  import utx_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Drain side and request
  input wire logic tx_take,
  input wire logic tx_avail,
  input wire logic [7:0] tx_byte,
  input wire logic serial_tx_transfer_request
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  req_pulse_a: assert property (serial_tx_transfer_request |=> !serial_tx_transfer_request)
    else $error("request wider than one cycle");
  req_quiet_a: assert property ($rose(reset_n) |-> !serial_tx_transfer_request)
    else $error("request at reset release");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  unmapped_zero_a: assert property (reg_rd && reg_addr == 8'h04 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  thresh_mask_a: assert property ((reg_wr && reg_addr == TX_DMA_THRESH_OFF) ##2
    (reg_rd && reg_addr == TX_DMA_THRESH_OFF) |=> reg_rdata == ($past(reg_wdata, 3) & 8'h3f))
    else $error("threshold readback wrong");
  status_bound_a: assert property (reg_rd && reg_addr == FIFO_STATUS_OFF |=>
    reg_rdata[6:0] <= 7'h40)
    else $error("fill count above depth");
  fifo_hold_a: assert property (tx_avail && !tx_take |=> tx_avail)
    else $error("byte lost without take");
  head_stable_a: assert property (tx_avail && !tx_take |=> $stable(tx_byte))
    else $error("head byte changed without take");
  empty_reset_a: assert property ($rose(reset_n) |-> !tx_avail)
    else $error("FIFO not empty after reset");
endmodule : utx_tx_dma_request_checker

bind utx_tx_dma_request utx_tx_dma_request_checker chk_i (.core_clk(core_clk),
  .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_take(tx_take), .tx_avail(tx_avail),
  .tx_byte(tx_byte), .serial_tx_transfer_request(serial_tx_transfer_request));

// >>> sim/utx_tx_dma_request_bench.sv
// Self-checking bench for the transmit FIFO and transfer request block.
// Assumes the checker is bound separately; a model counts requests.
`timescale 1ns/1ns
module utx_tx_dma_request_bench
  import utx_pkg::*;
;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, tx_byte, d;
  logic reg_wr = 1'b0, reg_rd = 1'b0, tx_take = 1'b0, tx_avail, serial_tx_transfer_request;
  int fails = 0, cmp_count = 0, req_count, base;
  logic [7:0] q[$];
  logic [7:0] offs[8] = '{8'h08, 8'h0c, 8'h10, 8'h1c, 8'h40, 8'h80, 8'h84, 8'h04};
  always #20 core_clk = ~core_clk;
  utx_tx_dma_request dut (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_take(tx_take), .tx_avail(tx_avail), .tx_byte(tx_byte),
    .serial_tx_transfer_request(serial_tx_transfer_request));
  utx_dma_ctrl_model dma (.core_clk(core_clk), .reset_n(reset_n),
    .serial_tx_transfer_request(serial_tx_transfer_request), .req_count(req_count));
  // ---------------------------------------------------------------
  // Expectations and bus tasks
  // ---------------------------------------------------------------
  function automatic logic [7:0] status_exp(input int cnt, input logic rdy);
    return {rdy, 7'(cnt)};
  endfunction : status_exp
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk(what, exp, reg_rdata);
  endtask : rd_chk
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h336d));
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    foreach (offs[i]) rd_chk("reset value", offs[i], 8'h00);
    rd_chk("status", FIFO_STATUS_OFF, status_exp(0, 1'b1));
    // Locked: modem and trigger writes must be dropped
    wr(MODEM_CONTROL_OFF, 8'h01 << TRIG_ACCESS_BIT);
    rd_chk("modem locked", MODEM_CONTROL_OFF, 8'h00);
    wr(TRIGGER_LEVEL_OFF, 8'h05);
    rd_chk("trigger locked", TRIGGER_LEVEL_OFF, 8'h00);
    wr(LINE_CONTROL_OFF, PORTAL_UNLOCK_VAL);
    wr(ENHANCED_FEATURE_OFF, 8'h01 << ENHANCED_EN_BIT);
    rd_chk("feature", ENHANCED_FEATURE_OFF, 8'h10);
    wr(MODEM_CONTROL_OFF, 8'h01 << TRIG_ACCESS_BIT);
    rd_chk("modem", MODEM_CONTROL_OFF, 8'h40);
    wr(LINE_CONTROL_OFF, PORTAL_FIFO_VAL);
    rd_chk("fifo control reset", ENHANCED_FEATURE_OFF, 8'h00);
    // Coarse trigger of eight entries on an empty FIFO: exactly one pulse
    base = req_count;
    wr(ENHANCED_FEATURE_OFF, 8'h01 << FIFO_CTRL_TRIG_LO);
    rd_chk("fifo control", ENHANCED_FEATURE_OFF, 8'h10);
    chk("trigger request", 8'(base + 1), 8'(req_count));
    wr(TRIGGER_LEVEL_OFF, 8'h05);
    rd_chk("trigger", TRIGGER_LEVEL_OFF, 8'h05);
    wr(TRIGGER_LEVEL_OFF, 8'h00);
    wr(SUPPLEMENTARY_OFF, 8'h01 << FINE_GRAN_BIT);
    rd_chk("supplementary", SUPPLEMENTARY_OFF, 8'h40);
    repeat (4) begin
      d = 8'($urandom);
      wr(TX_DMA_THRESH_OFF, d);
      rd_chk("threshold", TX_DMA_THRESH_OFF, d & 8'h3f);
    end
    // Threshold 62 plus trigger 1 keeps the sum at 63
    wr(TX_DMA_THRESH_OFF, 8'h3e);
    wr(MODE_DEF_3_OFF, 8'h01 << DMA_THRESH_EN_BIT);
    rd_chk("mode 3", MODE_DEF_3_OFF, 8'h04);
    // Condition stayed true across the mode changes: no second pulse
    chk("no extra request", 8'(base + 1), 8'(req_count));
    // Overfill on purpose, past the software limit, to hit both full points
    for (int i = 0; i < 80; i++) begin
      d = 8'($urandom);
      q.push_back(d);
      wr(TX_DATA_OFF, d);
      if (i == 63 || i == 79) begin
        repeat (4) @(posedge core_clk);
        rd_chk("status fill", FIFO_STATUS_OFF, status_exp(64, i == 63));
      end
    end
    wr(TX_DATA_OFF, 8'hee);
    // Drain with random stalls; one pulse once fill falls to threshold
    base = req_count;
    for (int n = 0; n < 1000 && q.size() > 0; n++) begin
      @(posedge core_clk);
      tx_take <= 1'($urandom % 3 != 0);
      @(negedge core_clk);
      if (tx_take === 1'b1 && tx_avail === 1'b1) begin
        chk("drained byte", q[0], tx_byte);
        void'(q.pop_front());
      end
    end
    if (q.size() > 0) begin
      chk("drain timeout", 8'h00, 8'(q.size()));
      tally_and_finish();
    end
    @(posedge core_clk);
    tx_take <= 1'b0;
    repeat (3) @(negedge core_clk);
    chk("empty after drain", 8'h00, {7'h00, tx_avail});
    chk("request after drain", 8'(base + 1), 8'(req_count));
    // Second reset mid-run: registers and FIFO state must clear
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    rd_chk("threshold after reset", TX_DMA_THRESH_OFF, 8'h00);
    rd_chk("status after reset", FIFO_STATUS_OFF, status_exp(0, 1'b1));
    tally_and_finish();
  end
endmodule : utx_tx_dma_request_bench
